// file: hw/pad_output_mux.sv
`include "parallel_io_regs.svh"

module pad_output_mux
#(
    parameter int WIDTH = `PIO_WIDTH
)
(
    // port side
    input  wire logic [WIDTH-1:0] port_data,
    input  wire logic [WIDTH-1:0] port_en_n,
    // peripheral side
    input  wire logic [WIDTH-1:0] periph_own,
    input  wire logic [WIDTH-1:0] periph_data,
    input  wire logic [WIDTH-1:0] periph_en_n,
    // pad side
    output logic      [WIDTH-1:0] pad_data,
    output logic      [WIDTH-1:0] pad_en_n
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            assign pad_data[i] = periph_own[i] ? periph_data[i] : port_data[i]; // see R8
            assign pad_en_n[i] = periph_own[i] ? periph_en_n[i] : port_en_n[i]; // see R8
        end
    endgenerate

endmodule : pad_output_mux

// file: hw/parallel_io_pkg.sv
`include "parallel_io_regs.svh"

package parallel_io_pkg;

    typedef logic [`PIO_WIDTH-1:0] pio_word_t;

    typedef enum logic [1:0]
    {
        sel_dir   = `PIO_SEL_DIR,
        sel_latch = `PIO_SEL_LATCH,
        sel_pin   = `PIO_SEL_PIN
    } pio_sel_e;

    // software access to the port
    typedef struct packed
    {
        logic      wr;
        pio_sel_e  sel;
        pio_word_t wdata;
    } pio_access_s;

    // peripheral side of the output muxes
    typedef struct packed
    {
        pio_word_t enabled;
        pio_word_t driving;
        pio_word_t out_data;
        pio_word_t out_en_n;
    } pio_periph_s;

    // pad cell signals
    typedef struct packed
    {
        pio_word_t out_data;
        pio_word_t out_en_n;
    } pio_pad_s;

endpackage : parallel_io_pkg

// file: hw/parallel_io_regs.svh
`ifndef PARALLEL_IO_REGS_SVH
`define PARALLEL_IO_REGS_SVH

// ------------------------------------------------------------
// port geometry and reset values
// ------------------------------------------------------------
`define PIO_WIDTH          16
`define PIO_IMPL_MASK      16'h03ff
`define PIO_DIR_RESET      16'hffff
`define PIO_LATCH_RESET    16'h0000

// ------------------------------------------------------------
// register select codes
// ------------------------------------------------------------
`define PIO_SEL_DIR        2'h0
`define PIO_SEL_LATCH      2'h1
`define PIO_SEL_PIN        2'h2

`endif

// file: hw/shared_parallel_io_port.sv
// Function
// R1: direction one is input, zero is output
// R2: reset sets every implemented direction bit
// R3: latch read returns latch, write latch
// R4: pin read returns pins, write hits latch
// R5: active peripheral disables port output driver
// R6: idle enabled peripheral leaves port driving
// R7: unimplemented bits disabled, all read zero
// R8: multiplexers pick peripheral or port per pad
// R9: analog pins read zero on pin read
// R10: software sets analog pins to input
// R11: software waits one cycle before port read
// R12: input-only shared pins stay dedicated port
// R13: analog select input forces pin read zero

`include "parallel_io_regs.svh"

module shared_parallel_io_port
#(
    parameter int                          WIDTH     = `PIO_WIDTH,
    parameter logic [`PIO_WIDTH-1:0]       IMPL_MASK = `PIO_IMPL_MASK
)
(
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    // software access
    input  wire parallel_io_pkg::pio_access_s acc,
    output logic [`PIO_WIDTH-1:0]          rdata,
    // configuration
    input  wire logic [`PIO_WIDTH-1:0]     analog_pin_select,
    input  wire logic [`PIO_WIDTH-1:0]     output_only_periph,
    // peripherals
    input  wire parallel_io_pkg::pio_periph_s periph,
    // pad cells
    input  wire logic [`PIO_WIDTH-1:0]     pad_in,
    output parallel_io_pkg::pio_pad_s      pad,
    // state view
    output logic [`PIO_WIDTH-1:0]          direction_reg,
    output logic [`PIO_WIDTH-1:0]          output_latch_reg
);

    import parallel_io_pkg::*;

    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    // write strobes out of the access decode
    logic           wr_dir;
    logic           wr_latch;
    // next register values
    wire pio_word_t next_direction;
    wire pio_word_t next_latch;
    pio_word_t      next_rdata;
    // per-bit results of the generate loops
    wire pio_word_t next_pin_value;
    wire pio_word_t periph_own;
    wire pio_word_t periph_en_n;
    wire pio_word_t port_en_n;
    // sampled pin levels
    pio_word_t      pin_value_reg;
    // one index for every per-bit loop
    genvar          b;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    // reset values trimmed to the pins that exist
    localparam pio_word_t DIR_RESET   = `PIO_DIR_RESET & IMPL_MASK;
    localparam pio_word_t LATCH_RESET = `PIO_LATCH_RESET & IMPL_MASK;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // a write to the pin-value register lands in the latch
    always_comb
    begin
        wr_dir   = 1'b0;
        wr_latch = 1'b0;
        if (acc.wr)
        begin
            case (acc.sel)
                sel_dir:
                begin
                    wr_dir   = 1'b1;
                    wr_latch = 1'b0;
                end
                sel_latch:
                begin
                    wr_dir   = 1'b0;
                    wr_latch = 1'b1; // see R3
                end
                sel_pin:
                begin
                    wr_dir   = 1'b0;
                    wr_latch = 1'b1; // see R4
                end
                default:
                begin
                    // the unused select code writes nothing
                    wr_dir   = 1'b0;
                    wr_latch = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // direction register
    // ------------------------------------------------------------
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_dir_next
            if (IMPL_MASK[b])
            begin : g_impl
                // write or hold
                assign next_direction[b] = wr_dir ? acc.wdata[b] : direction_reg[b]; // see R1
            end
            else
            begin : g_gap
                // missing bit stays cleared
                assign next_direction[b] = 1'b0; // see R7
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        // every implemented pin comes up as an input
        if (reset)
        begin
            direction_reg <= DIR_RESET; // see R2 see R7
        end
        else
        begin
            direction_reg <= next_direction;
        end
    end

    // ------------------------------------------------------------
    // output latch
    // ------------------------------------------------------------
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_latch_next
            if (IMPL_MASK[b])
            begin : g_impl
                // write or hold
                assign next_latch[b] = wr_latch ? acc.wdata[b] : output_latch_reg[b]; // see R3 see R4
            end
            else
            begin : g_gap
                // missing bit stays cleared
                assign next_latch[b] = 1'b0; // see R7
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        // latch clears, port drivers stay off until the direction register is written
        if (reset)
        begin
            output_latch_reg <= LATCH_RESET;
        end
        else
        begin
            output_latch_reg <= next_latch;
        end
    end

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_sample
            if (IMPL_MASK[b])
            begin : g_impl
                // analog pins never reach the read path
                assign next_pin_value[b] = pad_in[b] && !analog_pin_select[b]; // see R9 see R13
            end
            else
            begin : g_gap
                // missing pin reads zero
                assign next_pin_value[b] = 1'b0; // see R7
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        // two flop stages between pad and read data
        if (reset)
        begin
            pin_value_reg <= '0;
        end
        else
        begin
            pin_value_reg <= next_pin_value;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // read data follows the select of the previous cycle
    always_comb
    begin
        next_rdata = '0;
        case (acc.sel)
            sel_dir:
            begin
                next_rdata = direction_reg;
            end
            sel_latch:
            begin
                next_rdata = output_latch_reg; // see R3
            end
            sel_pin:
            begin
                next_rdata = pin_value_reg; // see R4 see R9
            end
            default:
            begin
                // the unused select code reads zero
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        // registered so read data stands for a full cycle
        if (reset)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // output ownership
    // ------------------------------------------------------------
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_owner
            if (IMPL_MASK[b])
            begin : g_impl
                // an idle or input-only peripheral leaves the pad to the port
                assign periph_own[b] = output_only_periph[b]
                                       && periph.enabled[b]
                                       && periph.driving[b]; // see R5 see R6 see R12
            end
            else
            begin : g_gap
                // missing pin has no peripheral
                assign periph_own[b] = 1'b0; // see R7
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // output enables
    // ------------------------------------------------------------
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_enable
            if (IMPL_MASK[b])
            begin : g_impl
                // port driver off for input direction
                assign port_en_n[b]   = direction_reg[b]; // see R1
                assign periph_en_n[b] = periph.out_en_n[b];
            end
            else
            begin : g_gap
                // missing pin is never driven
                assign port_en_n[b]   = 1'b1; // see R7
                assign periph_en_n[b] = 1'b1;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // pad multiplexers
    // ------------------------------------------------------------
    // data and enable of each pad come from one owner
    pad_output_mux
    #(
        .WIDTH       (WIDTH)
    )
    u_mux
    (
        .port_data   (output_latch_reg),
        .port_en_n   (port_en_n),
        .periph_own  (periph_own),
        .periph_data (periph.out_data),
        .periph_en_n (periph_en_n),
        .pad_data    (pad.out_data),
        .pad_en_n    (pad.out_en_n)
    ); // see R8

endmodule : shared_parallel_io_port

// file: verif/pio_pad_model.sv
module pio_pad_model
(
    input parallel_io_pkg::pio_pad_s pad,
    input logic [15:0] ext,
    output logic [15:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // undriven pins follow the outside level
    assign pad_in = (pad.out_data & ~pad.out_en_n) | (ext & pad.out_en_n);
endmodule : pio_pad_model

// file: verif/pio_port_checker.sv
module pio_port_checker
#(parameter logic [15:0] IMPL_MASK = 16'h03ff)
(
    // port view
    input logic clk_sys, reset,
    input parallel_io_pkg::pio_access_s acc,
    input parallel_io_pkg::pio_periph_s periph,
    input parallel_io_pkg::pio_pad_s pad,
    input logic [15:0] rdata, pad_in, analog_pin_select, output_only_periph,
    input logic [15:0] direction_reg, output_latch_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    import parallel_io_pkg::*;
    logic [15:0] own;
    assign own = periph.enabled & periph.driving & output_only_periph & IMPL_MASK;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_wr_lat; acc.wr && acc.sel inside {sel_latch, sel_pin}; endsequence
    property p_rst; $past(reset) |-> direction_reg == IMPL_MASK && output_latch_reg == '0;
    endproperty
    property p_dir; acc.wr && acc.sel == sel_dir |=> direction_reg == ($past(acc.wdata) & IMPL_MASK);
    endproperty
    property p_lat; s_wr_lat |=> output_latch_reg == ($past(acc.wdata) & IMPL_MASK); endproperty
    property p_rd; acc.sel != sel_pin |=> rdata == ($past(acc.sel) == sel_dir ? $past(direction_reg)
        : $past(acc.sel) == sel_latch ? $past(output_latch_reg) : '0); endproperty
    property p_pin; acc.sel == sel_pin |=>
        rdata == ($past(pad_in, 2) & ~$past(analog_pin_select, 2) & IMPL_MASK); endproperty
    property p_own; (((pad.out_en_n ^ periph.out_en_n) | (pad.out_data ^ periph.out_data)) & own) == '0;
    endproperty
    property p_port; (((pad.out_en_n ^ direction_reg) | (pad.out_data ^ output_latch_reg)
        & ~direction_reg) & ~own & IMPL_MASK) == '0; endproperty
    property p_gap; ((direction_reg | output_latch_reg) & ~IMPL_MASK) == '0; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    a_dir: assert property (p_dir) else $error("dir");
    a_lat: assert property (p_lat) else $error("lat");
    a_rd: assert property (p_rd) else $error("rd");
    a_pin: assert property (p_pin) else $error("pin");
    a_own: assert property (p_own) else $error("own");
    a_port: assert property (p_port) else $error("port");
    a_gap: assert property (p_gap) else $error("gap");
endmodule : pio_port_checker
bind shared_parallel_io_port pio_port_checker #(.IMPL_MASK(IMPL_MASK)) u_chk (.*);

// file: verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import parallel_io_pkg::*;
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin err_total++; \
$display("MISMATCH %s exp %h got %h", n, e, a); end end
    localparam logic [15:0] M = 16'h03ff;
    logic clk_sys, reset;
    pio_access_s acc;
    pio_periph_s periph;
    pio_pad_s pad;
    logic [15:0] rdata, pad_in, ext, analog_pin_select, output_only_periph;
    logic [15:0] direction_reg, output_latch_reg, ed, el, er, smp;
    int err_total, n_compared, seed = 9;
    shared_parallel_io_port #(.IMPL_MASK(M)) u_shared_parallel_io_port (.*);
    pio_pad_model u_pio_pad_model (.pad, .ext, .pad_in);
    initial
    begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    // reference of the port state
    always @(posedge clk_sys)
    begin
        smp <= pad_in & M;
        er <= reset ? '0 : acc.sel == sel_dir ? ed : acc.sel == sel_latch ? el
            : acc.sel == sel_pin ? smp & ~analog_pin_select : '0;
        ed <= reset ? M : acc.wr && acc.sel == sel_dir ? acc.wdata & M : ed;
        el <= reset ? '0 : acc.wr && acc.sel inside {sel_latch, sel_pin} ? acc.wdata & M : el;
    end
    always @(negedge clk_sys)
    if (!reset)
    begin
        `CHK("dir", ed, direction_reg)
        `CHK("lat", el, output_latch_reg)
        `CHK("rdata", er, rdata)
    end
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    initial
    begin
        {reset, acc, periph, analog_pin_select, output_only_periph, ext} = '0;
        reset = 1;
        for (int p = 0; p < 2; p++)
        begin
            repeat (10) @(posedge clk_sys) acc <= '0;
            analog_pin_select <= 16'($random(seed));
            reset <= 0;
            @(posedge clk_sys) acc <= {1'b1, sel_pin, 16'hffff};
            @(posedge clk_sys) acc <= {1'b1, sel_dir, 16'hffff};
            repeat (300) @(posedge clk_sys)
            begin
                acc <= pio_access_s'(19'($random(seed)));
                {periph, output_only_periph, ext} <= {$random(seed), $random(seed), $random(seed)};
            end
            $display("phase %0d done", p);
            reset <= 1;
        end
        results();
    end
endmodule : tb_top
